// >>> verilog/shutdown_map.svh
// Constants for the emergency shutdown block.
// Assumes inclusion by the shutdown package and design files.
`ifndef SHUTDOWN_MAP_SVH
`define SHUTDOWN_MAP_SVH
`define ERR_WIDTH 8
`define ERR_RESET 8'h00
`define PARK_TIME_NS 1000
`define CLK_PERIOD_NS 4
`define PARK_CYCLES ((`PARK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PARK_CNT_WIDTH 9
`endif

// >>> verilog/shutdown_pkg.sv
// Types for the emergency shutdown block.
// Assumes the constants header is on the include path.
`include "shutdown_map.svh"
package shutdown_pkg;
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_OPERATE,
		MODE_STANDBY
	} op_mode_t;
	typedef struct packed {
		logic led_enable;
		logic mirror_park;
		logic mirror_power;
	} drive_t;
	typedef struct packed {
		logic rd_req;
		logic [2:0] rd_index;
	} err_read_t;
endpackage : shutdown_pkg

// >>> verilog/emergency_shutdown_irq.sv
// Emergency shutdown sequencer with error history and host interrupt line.
// Assumes all inputs synchronous to clk_sys; rst is the power-cycle reset.
`timescale 1ns/10ps
`include "shutdown_map.svh"
module emergency_shutdown_irq
	import shutdown_pkg::*;
#(
	parameter int ERR_W = `ERR_WIDTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Power and errors
	input wire logic projector_power_request,
	input wire logic [ERR_W-1:0] error_flags,
	// Host command port
	input wire shutdown_pkg::err_read_t host_read,
	output logic host_rd_valid,
	output logic [ERR_W-1:0] host_rd_data,
	// Outputs
	output logic host_irq,
	output shutdown_pkg::drive_t drive,
	output shutdown_pkg::op_mode_t op_mode
);
	import shutdown_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_PARK,
		ST_DOWN
	} seq_t;

	seq_t state, next_state;
	logic [`PARK_CNT_WIDTH-1:0] park_cnt, next_park_cnt;
	logic [ERR_W-1:0] history, next_history;
	logic next_irq, next_rd_valid;
	logic [ERR_W-1:0] next_rd_data;
	drive_t next_drive;
	op_mode_t next_mode;
	logic err_any;

	assign err_any = |error_flags;

	always_comb begin
		next_state = state;
		next_park_cnt = park_cnt;
		next_history = history;
		next_irq = host_irq;
		next_drive = drive;
		next_mode = op_mode;
		next_rd_valid = 1'b0;
		next_rd_data = host_rd_data;
		case (state)
			ST_IDLE: begin
				if (projector_power_request) begin
					next_state = ST_RUN;
					next_mode = MODE_OPERATE;
					next_drive = '{led_enable: 1'b1, mirror_park: 1'b0, mirror_power: 1'b1};
				end
			end
			ST_RUN: begin
				if (err_any) begin
					next_state = ST_PARK;
					next_drive.led_enable = 1'b0;
					next_drive.mirror_park = 1'b1;
					next_mode = MODE_STANDBY;
					next_irq = 1'b1;
					next_park_cnt = '0;
				end else if (!projector_power_request) begin
					next_state = ST_IDLE;
					next_mode = MODE_OFF;
					next_drive = '0;
				end
			end
			ST_PARK: begin
				if (park_cnt == `PARK_CNT_WIDTH'(`PARK_CYCLES - 1)) begin
					next_state = ST_DOWN;
					next_drive.mirror_power = 1'b0;
				end else begin
					next_park_cnt = park_cnt + `PARK_CNT_WIDTH'(1);
				end
			end
			// Latched until power cycle; request drop is not a way out
			ST_DOWN: next_state = ST_DOWN;
			default: next_state = ST_IDLE;
		endcase
		if (state != ST_IDLE && (state != ST_RUN || err_any))
			next_history = history | error_flags;
		// Single history word, so the read index is not decoded
		// Host readout of history
		if (host_read.rd_req) begin
			next_rd_valid = 1'b1;
			next_rd_data = history;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_IDLE;
			park_cnt <= '0;
			history <= ERR_W'(`ERR_RESET);
			host_irq <= 1'b0;
			drive <= '0;
			op_mode <= MODE_OFF;
			host_rd_valid <= 1'b0;
			host_rd_data <= '0;
		end else begin
			state <= next_state;
			park_cnt <= next_park_cnt;
			history <= next_history;
			host_irq <= next_irq;
			drive <= next_drive;
			op_mode <= next_mode;
			host_rd_valid <= next_rd_valid;
			host_rd_data <= next_rd_data;
		end
	end

	// Park span counted apart
	// Kept apart from the sequencer counter so a fault there still shows
	localparam logic [`PARK_CNT_WIDTH-1:0] PARK_LAST = `PARK_CNT_WIDTH'(`PARK_CYCLES - 1);
	logic [`PARK_CNT_WIDTH-1:0] park_age, next_park_age;

	always_comb begin
		next_park_age = park_age;
		if (!drive.mirror_park)
			next_park_age = '0;
		else if (drive.mirror_power)
			next_park_age = park_age + `PARK_CNT_WIDTH'(1);
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			park_age <= '0;
		else
			park_age <= next_park_age;
	end

	// Reset disables all checks but the clear check
	irq_on_error_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_RUN && err_any |=> host_irq && state == ST_PARK)
		else $error("interrupt not raised on error");
	led_off_a: assert property (@(posedge clk_sys) disable iff (rst)
		host_irq |-> !drive.led_enable)
		else $error("leds on during shutdown");
	park_then_off_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(drive.mirror_park) |-> drive.mirror_power [*8] ##[1:300] !drive.mirror_power)
		else $error("mirror power sequence wrong");
	standby_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
		host_irq |-> op_mode == MODE_STANDBY)
		else $error("mode not standby");
	history_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_RUN && err_any |=> (history & $past(error_flags)) == $past(error_flags))
		else $error("error not latched");
	irq_high_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_DOWN |-> host_irq)
		else $error("interrupt low in shutdown");
	read_back_a: assert property (@(posedge clk_sys) disable iff (rst)
		host_read.rd_req |=> host_rd_valid && host_rd_data == $past(history))
		else $error("readout mismatch");
	no_escape_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_DOWN |=> state == ST_DOWN)
		else $error("left shutdown without power cycle");
	irq_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
		host_irq |=> host_irq)
		else $error("interrupt dropped");
	clear_hist_a: assert property (@(posedge clk_sys)
		rst |=> history == '0 && !host_irq)
		else $error("history not cleared");
	park_span_a: assert property (@(posedge clk_sys) disable iff (rst)
		drive.mirror_park && drive.mirror_power && park_age == PARK_LAST |=> !drive.mirror_power)
		else $error("mirror power not dropped after park time");
	park_early_a: assert property (@(posedge clk_sys) disable iff (rst)
		drive.mirror_park && drive.mirror_power && park_age != PARK_LAST |=> drive.mirror_power)
		else $error("mirror power dropped before park time");
	down_dark_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_DOWN |-> drive.mirror_park && !drive.mirror_power && !drive.led_enable)
		else $error("mirror or leds live after shutdown");
	idle_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_IDLE |=> history == $past(history))
		else $error("error latched while idle");
	late_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_DOWN |=> (history & $past(history)) == $past(history))
		else $error("history lost a bit");
	rd_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		!host_read.rd_req |=> !host_rd_valid)
		else $error("read answer without request");
	quiet_before_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_IDLE || state == ST_RUN |-> !host_irq)
		else $error("interrupt high before shutdown");
	run_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_IDLE && projector_power_request |=> state == ST_RUN && op_mode == MODE_OPERATE)
		else $error("no start after power request");

	shutdown_c: cover property (@(posedge clk_sys) disable iff (rst) state == ST_DOWN);
	read_c: cover property (@(posedge clk_sys) disable iff (rst) host_irq && host_rd_valid);
	normal_off_c: cover property (@(posedge clk_sys) disable iff (rst)
		state == ST_RUN ##1 state == ST_IDLE);
	// Refused cases: idle errors, request drop after shutdown
	idle_error_c: cover property (@(posedge clk_sys) disable iff (rst) state == ST_IDLE && err_any);
	drop_ignored_c: cover property (@(posedge clk_sys) disable iff (rst)
		state == ST_DOWN && !projector_power_request);
endmodule : emergency_shutdown_irq

// >>> dv/host_model.sv
// Host processor model on the command port.
// Assumes it shares clk_sys with the device.
`timescale 1ns/10ps
module host_model
	import shutdown_pkg::*;
(
	// Clock and control
	input wire logic clk_sys,
	input wire logic power_on,
	// Device side
	input wire logic host_irq,
	input wire logic host_rd_valid,
	input wire logic [7:0] host_rd_data,
	output logic projector_power_request,
	output shutdown_pkg::err_read_t host_read = '0,
	output logic [7:0] got = '0
);
	logic asked = 0;
	always @(negedge clk_sys) begin
		host_read.rd_req <= host_irq & !asked & power_on;
		asked <= power_on & (asked | host_irq);
	end
	// Taken at the falling edge, where the answer has settled
	always @(negedge clk_sys) begin
		got <= !power_on ? 8'h00 : host_rd_valid ? host_rd_data : got;
	end
	assign projector_power_request = power_on & !(asked & got != 8'h00);
endmodule : host_model

// >>> dv/emergency_shutdown_irq_tb.sv
// Bench for the emergency shutdown block.
// Assumes the host model answers the interrupt.
`timescale 1ns/10ps
module emergency_shutdown_irq_tb;
	import shutdown_pkg::*;
	logic clk_sys = 0;
	logic rst = 1;
	logic power_on = 0;
	logic [7:0] error_flags = '0;
	logic projector_power_request, host_rd_valid, host_irq;
	logic [7:0] host_rd_data, got;
	err_read_t host_read;
	drive_t drive;
	op_mode_t op_mode;
	int fails = 0;
	int checked = 0;
	int reads = 0;
	always #2 clk_sys = ~clk_sys;
	emergency_shutdown_irq u_emergency_shutdown_irq (.clk_sys(clk_sys), .rst(rst),
		.projector_power_request(projector_power_request), .error_flags(error_flags),
		.host_read(host_read), .host_rd_valid(host_rd_valid),
		.host_rd_data(host_rd_data), .host_irq(host_irq), .drive(drive), .op_mode(op_mode));
	host_model u_host_model (.clk_sys(clk_sys), .power_on(power_on), .host_irq(host_irq),
		.host_rd_valid(host_rd_valid), .host_rd_data(host_rd_data), .got(got),
		.projector_power_request(projector_power_request), .host_read(host_read));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// One-cycle read answers counted where settled
	always @(negedge clk_sys) begin
		if (host_rd_valid)
			reads++;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	// Packed view: irq, led, park, power, mode
	function automatic logic [7:0] st();
		return {1'b0, host_irq, drive, 1'b0, op_mode};
	endfunction : st
	task automatic power_cycle();
		rst = 1;
		power_on = 0;
		error_flags = 8'h80;
		tick(4);
		rst = 0;
		chk(st(), 8'h00);
		tick(1);
		error_flags = 8'h00;
		chk(st(), 8'h00);
	endtask : power_cycle
	task automatic run_and_stop();
		power_on = 1;
		tick(1);
		chk(st(), 8'h29);
		power_on = 0;
		tick(1);
		chk(st(), 8'h00);
		error_flags = 8'h40;
		tick(1);
		error_flags = 8'h00;
		chk(st(), 8'h00);
	endtask : run_and_stop
	task automatic run_and_trip(input logic [7:0] err);
		int reads0;
		reads0 = reads;
		power_on = 1;
		tick(1);
		chk(st(), 8'h29);
		error_flags = err;
		tick(1);
		error_flags = 8'h00;
		chk(st(), 8'h5a);
		tick(249);
		chk(st(), 8'h5a);
		tick(1);
		chk(st(), 8'h52);
		chk(got, err);
		chk(8'(reads - reads0), 8'h01);
	endtask : run_and_trip
	task automatic tally_and_finish();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		#20000;
		fails++;
		tally_and_finish();
	end
	initial begin
		power_cycle();
		run_and_stop();
		run_and_trip(8'h05);
		power_cycle();
		run_and_trip(8'h30);
		tally_and_finish();
	end
endmodule : emergency_shutdown_irq_tb
